// [logic/pmp_pkg.sv]
// Operation
// - boot block of 2 or 4 KB plus two binary blocks, three guards each.
// - table accesses may address any program location, subject to guards.
// - table reads of the identification address return the id value.
// - config words are table readable and writable unless write guarded.
// - in normal execution block read guards do not restrict table access.
// - programmer access to a block is refused while its read guard is 0.
// - table writes into a block whose write guard is 0 are dropped.
// - cross block read guard 0 still lets code inside that block read it.
// - cross block read guard 0 makes reads by outside code return zeros.
// - writes change guard bits only from one to zero, never back.
// - guard bits return to one only by chip erase or block erase; here rst_n also reloads every guard to one.
// - chip and block erase are accepted only from the programming port.
// - the config write guard decides whether table writes may change config words.
// - in normal execution the config write guard bit is read only.
// - eight user id locations, open to table and programmer access.
// - user id locations stay readable while program blocks are protected.
package pmp_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  typedef logic [21:0] pmp_addr_t;
  localparam pmp_addr_t BOOT_END_SMALL = 22'h0007ff;
  localparam pmp_addr_t BOOT_END_BIG = 22'h000fff;
  localparam pmp_addr_t BLK0_END = 22'h001fff;
  localparam pmp_addr_t BLK1_END = 22'h003fff;
  localparam pmp_addr_t ID_BASE = 22'h200000;
  localparam pmp_addr_t ID_END = 22'h200007;
  localparam pmp_addr_t CFG_BASE = 22'h300000;
  localparam pmp_addr_t CFG_END = 22'h30000d;
  localparam pmp_addr_t DEVID_LO = 22'h3ffffe;
  localparam pmp_addr_t DEVID_HI = 22'h3fffff;

  // guard byte offsets within the configuration space
  localparam logic [3:0] OFF_RD_LO = 4'h8;
  localparam logic [3:0] OFF_RD_HI = 4'h9;
  localparam logic [3:0] OFF_WR_LO = 4'ha;
  localparam logic [3:0] OFF_WR_HI = 4'hb;
  localparam logic [3:0] OFF_XRD_LO = 4'hc;
  localparam logic [3:0] OFF_XRD_HI = 4'hd;
  // bit positions inside the high guard bytes
  localparam int POS_BOOT = 6;
  localparam int POS_CFG = 5;

  // block indices: 0 and 1 are the binary blocks, 2 the boot block
  localparam logic [1:0] IDX_BLK0 = 2'h0;
  localparam logic [1:0] IDX_BLK1 = 2'h1;
  localparam logic [1:0] IDX_BOOT = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RG_BOOT, RG_BLK0, RG_BLK1, RG_ID, RG_CFG, RG_DEVID, RG_NONE
  } pmp_region_t;

  typedef enum logic [1:0] {
    SRC_ZERO, SRC_FLASH, SRC_DEVID, SRC_GUARD
  } pmp_src_t;

  typedef struct packed {
    logic [2:0] rd;
    logic [2:0] wr;
    logic [2:0] xrd;
    logic cfg_wr;
  } pmp_guard_t;

  typedef struct packed {
    logic we;
    pmp_addr_t addr;
    logic [7:0] data;
  } pmp_req_t;

  // erased state: every guard released
  localparam pmp_guard_t GUARD_RST = 10'h3ff;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic pmp_is_mem(input pmp_region_t r);
    return (r == RG_BOOT) || (r == RG_BLK0) || (r == RG_BLK1);
  endfunction

  function automatic logic [1:0] pmp_blk_idx(input pmp_region_t r);
    case (r)
      RG_BLK0: return IDX_BLK0;
      RG_BLK1: return IDX_BLK1;
      default: return IDX_BOOT;
    endcase
  endfunction

  function automatic logic [7:0] pmp_guard_byte(input pmp_guard_t g,
                                                input logic [3:0] off);
    logic [7:0] b;
    b = 8'h00;
    case (off)
      OFF_RD_LO: b[1:0] = g.rd[1:0];
      OFF_RD_HI: b[POS_BOOT] = g.rd[2];
      OFF_WR_LO: b[1:0] = g.wr[1:0];
      OFF_WR_HI: begin
        b[POS_BOOT] = g.wr[2];
        b[POS_CFG] = g.cfg_wr;
      end
      OFF_XRD_LO: b[1:0] = g.xrd[1:0];
      OFF_XRD_HI: b[POS_BOOT] = g.xrd[2];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // and-merge: a written one never raises a cleared guard
  function automatic pmp_guard_t pmp_guard_write(input pmp_guard_t g,
                                                 input logic [3:0] off,
                                                 input logic [7:0] d,
                                                 input logic ext);
    pmp_guard_t n;
    n = g;
    case (off)
      OFF_RD_LO: n.rd[1:0] = g.rd[1:0] & d[1:0];
      OFF_RD_HI: n.rd[2] = g.rd[2] & d[POS_BOOT];
      OFF_WR_LO: n.wr[1:0] = g.wr[1:0] & d[1:0];
      OFF_WR_HI: begin
        n.wr[2] = g.wr[2] & d[POS_BOOT];
        if (ext) begin
          n.cfg_wr = g.cfg_wr & d[POS_CFG];
        end
      end
      OFF_XRD_LO: n.xrd[1:0] = g.xrd[1:0] & d[1:0];
      OFF_XRD_HI: n.xrd[2] = g.xrd[2] & d[POS_BOOT];
      default: n = g;
    endcase
    return n;
  endfunction

endpackage

// [logic/pmp_region_dec.sv]
module pmp_region_dec
  import pmp_pkg::*;
(
  // address in
  input wire pmp_addr_t addr,
  input wire logic boot_big,
  // decoded region
  output pmp_region_t region
);

  pmp_addr_t boot_end;
  assign boot_end = boot_big ? BOOT_END_BIG : BOOT_END_SMALL;

  // unimplemented space falls through to none and reads as zero
  always_comb begin
    if (addr <= boot_end) begin
      region = RG_BOOT;
    end else if (addr <= BLK0_END) begin
      region = RG_BLK0;
    end else if (addr <= BLK1_END) begin
      region = RG_BLK1;
    end else if (addr >= ID_BASE && addr <= ID_END) begin
      region = RG_ID;
    end else if (addr >= CFG_BASE && addr <= CFG_END) begin
      region = RG_CFG;
    end else if (addr >= DEVID_LO && addr <= DEVID_HI) begin
      region = RG_DEVID;
    end else begin
      region = RG_NONE;
    end
  end

endmodule

// [logic/pmp_guard_unit.sv]
module pmp_guard_unit
  import pmp_pkg::*;
#(
  // identification value, arbitrary
  parameter logic [15:0] DEV_ID = 16'h5a3c
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // static configuration
  input wire logic boot_big,
  // processor table access
  input wire logic tbl_req,
  input wire pmp_req_t tbl,
  input wire pmp_addr_t tbl_pc,
  output logic tbl_ack,
  output logic [7:0] tbl_rdata,
  // external programmer
  input wire logic prog_mode,
  input wire logic prog_req,
  input wire pmp_req_t prog,
  input wire logic prog_chip_erase,
  input wire logic prog_blk_erase,
  input wire logic [1:0] prog_erase_sel,
  output logic prog_ack,
  output logic [7:0] prog_rdata,
  output logic prog_refused,
  // flash array
  output logic flash_rd,
  output logic flash_wr,
  output pmp_addr_t flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_erase_chip,
  output logic flash_erase_blk,
  output logic [1:0] flash_erase_sel,
  input wire logic [7:0] flash_rdata,
  // guard state
  output pmp_guard_t guard
);

  // ----------------------------------------------------------------
  // request select and decode
  // ----------------------------------------------------------------
  // the processor is held off while the programmer owns the part
  pmp_req_t rq;
  logic act;
  pmp_region_t tgt_rg;
  pmp_region_t src_rg;
  logic [1:0] idx;
  logic mem;
  logic same_blk;
  logic is_guard;
  logic er_chip;
  logic er_blk;

  assign rq = prog_mode ? prog : tbl;
  assign act = prog_mode ? prog_req : tbl_req;

  pmp_region_dec u_tgt_dec (
    .addr(rq.addr),
    .boot_big(boot_big),
    .region(tgt_rg)
  );

  pmp_region_dec u_src_dec (
    .addr(tbl_pc),
    .boot_big(boot_big),
    .region(src_rg)
  );

  assign idx = pmp_blk_idx(tgt_rg);
  assign mem = pmp_is_mem(tgt_rg);
  assign same_blk = (src_rg == tgt_rg);
  assign is_guard = (tgt_rg == RG_CFG) && (rq.addr[3:0] >= OFF_RD_LO);
  assign er_chip = prog_mode && prog_chip_erase;
  assign er_blk = prog_mode && prog_blk_erase && (prog_erase_sel <= IDX_BOOT);

  // ----------------------------------------------------------------
  // access decision
  // ----------------------------------------------------------------
  logic next_rd;
  logic next_wr;
  logic next_gwr;
  logic next_refused;
  pmp_src_t next_src;

  always_comb begin
    next_rd = 1'b0;
    next_wr = 1'b0;
    next_gwr = 1'b0;
    next_refused = 1'b0;
    next_src = SRC_ZERO;
    if (act) begin
      case (tgt_rg)
        RG_BOOT, RG_BLK0, RG_BLK1: begin
          if (prog_mode) begin
            if (!guard.rd[idx]) begin
              next_refused = 1'b1;
            end else if (rq.we) begin
              next_wr = 1'b1;
            end else begin
              next_rd = 1'b1;
              next_src = SRC_FLASH;
            end
          end else if (rq.we) begin
            // read guard is not consulted here
            next_wr = guard.wr[idx];
          end else if (guard.xrd[idx] || same_blk) begin
            next_rd = 1'b1;
            next_src = SRC_FLASH;
          end
          // otherwise the answer stays zero
        end
        RG_ID: begin
          next_wr = rq.we;
          next_rd = !rq.we;
          next_src = rq.we ? SRC_ZERO : SRC_FLASH;
        end
        RG_CFG: begin
          if (rq.we) begin
            if (prog_mode || guard.cfg_wr) begin
              next_gwr = is_guard;
              next_wr = !is_guard;
            end
          end else begin
            next_rd = !is_guard;
            next_src = is_guard ? SRC_GUARD : SRC_FLASH;
          end
        end
        RG_DEVID: begin
          next_src = rq.we ? SRC_ZERO : SRC_DEVID;
        end
        default: begin
          next_src = SRC_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // guard bits
  // ----------------------------------------------------------------
  // erase wins over a write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      guard <= GUARD_RST;
    end else if (er_chip) begin
      guard <= GUARD_RST;
    end else if (er_blk) begin
      guard.rd[prog_erase_sel] <= 1'b1;
      guard.wr[prog_erase_sel] <= 1'b1;
      guard.xrd[prog_erase_sel] <= 1'b1;
    end else if (next_gwr) begin
      // config write guard only moves from the programmer side
      guard <= pmp_guard_write(guard, rq.addr[3:0], rq.data,
                               prog_mode);
    end
  end

  // ----------------------------------------------------------------
  // stage 1: flash strobes
  // ----------------------------------------------------------------
  logic s1_valid;
  logic s1_prog;
  logic s1_refused;
  logic s1_hi;
  pmp_src_t s1_src;
  logic [7:0] s1_gbyte;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_rd <= 1'b0;
      flash_wr <= 1'b0;
      flash_addr <= '0;
      flash_wdata <= 8'h00;
      flash_erase_chip <= 1'b0;
      flash_erase_blk <= 1'b0;
      flash_erase_sel <= 2'h0;
    end else begin
      flash_rd <= next_rd;
      flash_wr <= next_wr;
      flash_addr <= rq.addr;
      flash_wdata <= rq.data;
      flash_erase_chip <= er_chip;
      flash_erase_blk <= er_blk;
      flash_erase_sel <= prog_erase_sel;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_valid <= 1'b0;
      s1_prog <= 1'b0;
      s1_refused <= 1'b0;
      s1_hi <= 1'b0;
      s1_src <= SRC_ZERO;
      s1_gbyte <= 8'h00;
    end else begin
      s1_valid <= act;
      s1_prog <= prog_mode;
      s1_refused <= next_refused;
      s1_hi <= rq.addr[0];
      s1_src <= next_src;
      s1_gbyte <= pmp_guard_byte(guard, rq.addr[3:0]);
    end
  end

  // ----------------------------------------------------------------
  // stage 2: answer
  // ----------------------------------------------------------------
  // every access, blocked or not, answers two cycles on; a refused programmer access also raises prog_refused
  logic [7:0] ans;

  always_comb begin
    case (s1_src)
      SRC_FLASH: ans = flash_rdata;
      SRC_DEVID: ans = s1_hi ? DEV_ID[15:8] : DEV_ID[7:0];
      SRC_GUARD: ans = s1_gbyte;
      default: ans = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_ack <= 1'b0;
      tbl_rdata <= 8'h00;
      prog_ack <= 1'b0;
      prog_rdata <= 8'h00;
      prog_refused <= 1'b0;
    end else begin
      tbl_ack <= s1_valid && !s1_prog;
      prog_ack <= s1_valid && s1_prog;
      prog_refused <= s1_valid && s1_prog && s1_refused;
      if (s1_valid && !s1_prog) begin
        tbl_rdata <= ans;
      end
      if (s1_valid && s1_prog) begin
        prog_rdata <= ans;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic cpu_rd;
  logic cpu_wr;
  logic prg_rd;
  assign cpu_rd = act && !prog_mode && !rq.we;
  assign cpu_wr = act && !prog_mode && rq.we;
  assign prg_rd = act && prog_mode && !rq.we;

  xrd_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_rd && mem && !guard.xrd[idx] && !same_blk)
      |=> !flash_rd ##1 (tbl_ack && tbl_rdata == 8'h00))
    else $error("cross block read did not return zero");

  same_blk_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_rd && mem && same_blk) |=> flash_rd ##1 tbl_ack)
    else $error("same block read was not passed to flash");

  wr_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_wr && mem && !guard.wr[idx]) |=> !flash_wr ##1 tbl_ack)
    else $error("write into guarded block reached flash");

  prog_refuse_a: assert property (@(posedge clk)
    disable iff (!rst_n) (act && prog_mode && mem && !guard.rd[idx])
      |=> (!flash_rd && !flash_wr) ##1 (prog_ack && prog_refused))
    else $error("programmer access to guarded block not refused");

  one_way_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(er_chip || er_blk) |=> ((guard & ~$past(guard)) == '0))
    else $error("guard bit rose without an erase");

  cfg_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
    !prog_mode |=> $stable(guard.cfg_wr))
    else $error("config write guard changed in normal execution");

  erase_port_a: assert property (@(posedge clk)
    disable iff (!rst_n) !prog_mode |=> !(flash_erase_chip || flash_erase_blk))
    else $error("erase issued outside programming mode");

  devid_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_rd && tgt_rg == RG_DEVID)
      |-> ##2 (tbl_ack && tbl_rdata == ($past(rq.addr[0], 2) ?
                                        DEV_ID[15:8] : DEV_ID[7:0])))
    else $error("identification read returned wrong value");

  id_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (prg_rd && tgt_rg == RG_ID) |=> flash_rd ##1 !prog_refused)
    else $error("id location read blocked");

  cfg_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_wr && tgt_rg == RG_CFG && !guard.cfg_wr)
      |=> (!flash_wr && $stable(guard)))
    else $error("config write passed while write guarded");

endmodule

// [dv/pmp_flash_model.sv]
module pmp_flash_model
  import pmp_pkg::*;
(
  // clock and layout
  input wire logic clk,
  input wire logic boot_big,
  // array strobes
  input wire logic flash_rd,
  input wire logic flash_wr,
  input wire pmp_addr_t flash_addr,
  input wire logic [7:0] flash_wdata,
  input wire logic flash_erase_chip,
  input wire logic flash_erase_blk,
  input wire logic [1:0] flash_erase_sel,
  output logic [7:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // sparse byte array, erased bytes read 8'hff
  // ----------------------------------------------------------------
  logic [7:0] mem [pmp_addr_t];
  logic [7:0] junk = 8'h3c;
  pmp_addr_t lo;
  pmp_addr_t hi;
  always @(posedge clk) begin
    // idle data wanders so a late sample never looks right by luck
    junk <= junk + 8'h1d;
    lo = (flash_erase_sel == 2'h2) ? 22'h000000 :
         (flash_erase_sel == 2'h1) ? BLK0_END + 22'h1 :
         (boot_big ? BOOT_END_BIG : BOOT_END_SMALL) + 22'h1;
    hi = (flash_erase_sel == 2'h2) ?
         (boot_big ? BOOT_END_BIG : BOOT_END_SMALL) :
         (flash_erase_sel == 2'h1) ? BLK1_END : BLK0_END;
    if (flash_wr) begin
      mem[flash_addr] = flash_wdata;
    end
    if (flash_erase_chip) begin
      mem.delete();
    end
    if (flash_erase_blk) begin
      foreach (mem[k]) begin
        if (k >= lo && k <= hi) begin
          mem[k] = 8'hff;
        end
      end
    end
  end
  always @(flash_rd or flash_addr or junk) begin
    if (!flash_rd) begin
      flash_rdata = junk;
    end else if (mem.exists(flash_addr)) begin
      flash_rdata = mem[flash_addr];
    end else begin
      flash_rdata = 8'hff;
    end
  end
endmodule

// [dv/tb_top.sv]
module tb_top
  import pmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // identification value, arbitrary
  localparam logic [15:0] ID_VAL = 16'h1e2d;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic boot_big = 1'b0;
  logic tbl_req = 1'b0;
  pmp_req_t tbl = '0;
  pmp_addr_t tbl_pc = '0;
  logic tbl_ack;
  logic [7:0] tbl_rdata;
  logic prog_mode = 1'b0;
  logic prog_req = 1'b0;
  pmp_req_t prog = '0;
  logic prog_chip_erase = 1'b0;
  logic prog_blk_erase = 1'b0;
  logic [1:0] prog_erase_sel = 2'h0;
  logic prog_ack, prog_refused, flash_rd, flash_wr;
  logic [7:0] prog_rdata, flash_wdata, flash_rdata;
  logic flash_erase_chip, flash_erase_blk;
  logic [1:0] flash_erase_sel;
  pmp_addr_t flash_addr;
  pmp_guard_t guard;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  // boot size is a static level, switched only while the ports are idle
  pmp_guard_unit #(.DEV_ID(ID_VAL)) dut (
    .clk(clk), .rst_n(rst_n), .boot_big(boot_big), .tbl_req(tbl_req),
    .tbl(tbl), .tbl_pc(tbl_pc), .tbl_ack(tbl_ack), .tbl_rdata(tbl_rdata),
    .prog_mode(prog_mode), .prog_req(prog_req), .prog(prog),
    .prog_chip_erase(prog_chip_erase), .prog_blk_erase(prog_blk_erase),
    .prog_erase_sel(prog_erase_sel), .prog_ack(prog_ack),
    .prog_rdata(prog_rdata), .prog_refused(prog_refused),
    .flash_rd(flash_rd), .flash_wr(flash_wr), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_erase_chip(flash_erase_chip),
    .flash_erase_blk(flash_erase_blk), .flash_erase_sel(flash_erase_sel),
    .flash_rdata(flash_rdata), .guard(guard));
  pmp_flash_model mem (
    .clk(clk), .boot_big(boot_big), .flash_rd(flash_rd), .flash_wr(flash_wr),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_erase_chip(flash_erase_chip), .flash_erase_blk(flash_erase_blk),
    .flash_erase_sel(flash_erase_sel), .flash_rdata(flash_rdata));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // p selects the programmer port; answer is looked at in cycle 2
  task automatic acc(input bit p, input logic we, input pmp_addr_t a,
                     input logic [7:0] d, input pmp_addr_t pc,
                     input logic [7:0] e, input bit rf);
    @(posedge clk);
    prog_mode <= p;
    if (p) begin
      prog_req <= 1'b1;
      prog <= '{we, a, d};
    end else begin
      tbl_req <= 1'b1;
      tbl <= '{we, a, d};
      tbl_pc <= pc;
    end
    @(posedge clk);
    tbl_req <= 1'b0;
    prog_req <= 1'b0;
    @(posedge clk);
    #1;
    chk("ack", 16'h1, 16'(p ? prog_ack : tbl_ack));
    chk("other ack", 16'h0, 16'(p ? tbl_ack : prog_ack));
    if (p) begin
      chk("refused", 16'(rf), 16'(prog_refused));
    end
    if (!we) begin
      chk("rdata", 16'(e), 16'(p ? prog_rdata : tbl_rdata));
    end
  endtask
  task automatic erase(input bit chip, input logic [1:0] sel, input bit md);
    @(posedge clk);
    prog_mode <= md;
    prog_chip_erase <= chip;
    prog_blk_erase <= !chip;
    prog_erase_sel <= sel;
    @(posedge clk);
    prog_chip_erase <= 1'b0;
    prog_blk_erase <= 1'b0;
    #1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_plain();
    chk("guard rst", 16'(GUARD_RST), 16'(guard));
    acc(0, 1, 22'h001010, 8'ha5, 22'h000100, 0, 0);
    acc(0, 0, 22'h001010, 0, 22'h000100, 8'ha5, 0);
    acc(0, 1, 22'h002010, 8'h77, 22'h000100, 0, 0);
    acc(0, 0, DEVID_LO, 0, 22'h000100, ID_VAL[7:0], 0);
    acc(0, 0, DEVID_HI, 0, 22'h000100, ID_VAL[15:8], 0);
    acc(0, 1, CFG_BASE, 8'h3c, 22'h000100, 0, 0);
    acc(0, 0, CFG_BASE, 0, 22'h000100, 8'h3c, 0);
    acc(0, 1, ID_END, 8'h42, 22'h000100, 0, 0);
  endtask
  task automatic t_cross();
    acc(0, 1, 22'h30000c, 8'hfd, 22'h000100, 0, 0);
    chk("xrd", 16'h5, 16'(guard.xrd));
    acc(0, 0, 22'h002010, 0, 22'h000100, 8'h00, 0);
    acc(0, 0, 22'h002010, 0, 22'h002100, 8'h77, 0);
    acc(0, 0, 22'h002010, 0, 22'h001100, 8'h00, 0);
    acc(0, 0, 22'h30000c, 0, 22'h000100, 8'h01, 0);
  endtask
  task automatic t_write();
    acc(0, 1, 22'h30000a, 8'hfe, 22'h000100, 0, 0);
    acc(0, 1, 22'h000800, 8'h11, 22'h000100, 0, 0);
    acc(0, 1, BOOT_END_SMALL, 8'h5a, 22'h000100, 0, 0);
    acc(0, 0, 22'h000800, 0, 22'h000900, 8'hff, 0);
    acc(0, 0, BOOT_END_SMALL, 0, 22'h000100, 8'h5a, 0);
    acc(0, 1, 22'h30000a, 8'hff, 22'h000100, 0, 0);
    chk("wr", 16'h6, 16'(guard.wr));
  endtask
  task automatic t_read_guard();
    acc(0, 1, 22'h300008, 8'hfe, 22'h000100, 0, 0);
    acc(0, 0, 22'h001010, 0, 22'h000100, 8'ha5, 0);
    acc(1, 0, 22'h001010, 0, 22'h000100, 8'h00, 1);
    acc(1, 1, 22'h001010, 8'h33, 22'h000100, 0, 1);
    acc(0, 0, 22'h001010, 0, 22'h001100, 8'ha5, 0);
    acc(1, 0, ID_END, 0, 22'h000100, 8'h42, 0);
    acc(0, 0, ID_END, 0, 22'h000100, 8'h42, 0);
  endtask
  task automatic t_config();
    acc(0, 1, 22'h30000b, 8'hdf, 22'h000100, 0, 0);
    chk("cfg_wr cpu", 16'h1, 16'(guard.cfg_wr));
    acc(1, 1, 22'h30000b, 8'hdf, 22'h000100, 0, 0);
    chk("cfg_wr prog", 16'h0, 16'(guard.cfg_wr));
    acc(0, 1, CFG_BASE, 8'h99, 22'h000100, 0, 0);
    acc(0, 0, CFG_BASE, 0, 22'h000100, 8'h3c, 0);
    acc(1, 0, 22'h30000b, 0, 22'h000100, 8'h40, 0);
  endtask
  task automatic t_erase();
    pmp_guard_t g0;
    g0 = guard;
    erase(1, 2'h0, 0);
    chk("no cpu erase", 16'(g0), 16'(guard));
    erase(0, 2'h3, 1);
    chk("sel 3 erase", 16'(g0), 16'(guard));
    erase(0, 2'h0, 1);
    chk("blk0 rd", 16'h7, 16'(guard.rd));
    chk("blk0 wr", 16'h7, 16'(guard.wr));
    chk("blk0 xrd", 16'h5, 16'(guard.xrd));
    acc(0, 0, 22'h001010, 0, 22'h000100, 8'hff, 0);
    erase(0, 2'h1, 1);
    chk("blk1 xrd", 16'h7, 16'(guard.xrd));
    acc(0, 0, 22'h002010, 0, 22'h000100, 8'hff, 0);
    erase(1, 2'h0, 1);
    chk("chip", 16'(GUARD_RST), 16'(guard));
  endtask
  // large boot block moves 0x800 from block 0 into boot; unmapped reads 0
  task automatic t_boot();
    @(posedge clk);
    boot_big <= 1'b1;
    acc(0, 1, 22'h000800, 8'h66, 22'h000100, 0, 0);
    acc(0, 0, 22'h000800, 0, 22'h000100, 8'h66, 0);
    acc(0, 0, 22'h100000, 0, 22'h000100, 8'h00, 0);
    @(posedge clk);
    boot_big <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_plain();
    t_cross();
    t_write();
    t_boot();
    t_read_guard();
    t_config();
    t_erase();
    report_and_stop();
  end
endmodule
